/* logic/ctm_consts.vh */
`ifndef CTM_CONSTS_VH
`define CTM_CONSTS_VH
`define CTM_ADDR_CTRL0     4'h0
`define CTM_ADDR_CTRL1     4'h1
`define CTM_ADDR_CNT_LO    4'h2
`define CTM_ADDR_CNT_HI    4'h3
`define CTM_ADDR_CMPA_LO   4'h4
`define CTM_ADDR_CMPA_HI   4'h5
`define CTM_ADDR_FLAGS     4'h6
`define CTM_MODE_CMP       2'h0
`define CTM_MODE_PWM       2'h2
`define CTM_MODE_TMR       2'h3
`define CTM_ACT_NONE       2'h0
`define CTM_ACT_LOW        2'h1
`define CTM_ACT_HIGH       2'h2
`define CTM_ACT_TOGGLE     2'h3
`define CTM_PWM_INACTIVE   2'h0
`define CTM_PWM_ACTIVE     2'h1
`define CTM_PWM_WAVE       2'h2
`define CTM_CNT_MAX        10'h3FF
`define CTM_PERIOD_SHIFT   7
`define CTM_BIT_ON         3
`define CTM_BIT_PER_HI     2
`define CTM_BIT_MODE_HI    7
`define CTM_BIT_MODE_LO    6
`define CTM_BIT_ACT_HI     5
`define CTM_BIT_ACT_LO     4
`define CTM_BIT_INIT       3
`define CTM_BIT_INV        2
`define CTM_BIT_SWAP       1
`define CTM_BIT_CLRSEL     0
`define CTM_BIT_FLAG_A     0
`define CTM_BIT_FLAG_P     1
`define CTM_RST_BYTE       8'h00
`endif

/* logic/ctm_timer.v */
`timescale 1ns/1ps
`include "ctm_consts.vh"
module ctm_timer #(
   parameter CNT_W = 10
) (
   input  wire             i_clk,
   input  wire             i_rst_n,
   input  wire             i_tick,
   input  wire [3:0]       i_address,
   input  wire             i_read,
   input  wire             i_write,
   input  wire [31:0]      i_writedata,
   output reg  [31:0]      o_readdata,
   output reg              o_waitrequest,
   output reg              o_pin,
   output reg              o_pin_oe
);

   reg  [7:0]       ctrl0;
   reg  [7:0]       ctrl1;
   reg  [CNT_W-1:0] compare_a_value;
   reg  [CNT_W-1:0] count;
   reg              match_a_flag;
   reg              match_p_flag;
   reg              pwm_wave;
   reg              on_dly;

   wire [1:0]       mode = {ctrl1[`CTM_BIT_MODE_HI], ctrl1[`CTM_BIT_MODE_LO]};
   wire [1:0]       act  = {ctrl1[`CTM_BIT_ACT_HI], ctrl1[`CTM_BIT_ACT_LO]};
   wire             init_lvl     = ctrl1[`CTM_BIT_INIT];
   wire             invert       = ctrl1[`CTM_BIT_INV];
   wire             swap         = ctrl1[`CTM_BIT_SWAP];
   wire             clear_select = ctrl1[`CTM_BIT_CLRSEL];
   wire             counter_on   = ctrl0[`CTM_BIT_ON];
   wire [2:0]       period_compare_value = ctrl0[`CTM_BIT_PER_HI:0];
   wire             is_pwm = (mode == `CTM_MODE_PWM);
   wire             is_cmp = (mode == `CTM_MODE_CMP) | (mode == `CTM_MODE_TMR);
   wire             on_rise = counter_on & ~on_dly;
   wire             run = counter_on & i_tick & ~on_rise;

   // Three-bit code to a full-width threshold; code zero means full range
   function [CNT_W:0] ctm_scale;
      input [2:0] code;
      begin
         if (code == 3'h0)
            ctm_scale = ({{CNT_W{1'b0}}, 1'b1} << CNT_W);
         else
            ctm_scale = {{(CNT_W-2){1'b0}}, code} << `CTM_PERIOD_SHIFT;
      end
   endfunction

   // Top bits plus all-ones low bits, so P matches fall one count before 128-count multiples
   wire             p_hit = (count[CNT_W-1:CNT_W-3] == period_compare_value - 3'h1) &
                            (count[CNT_W-4:0] == {(CNT_W-3){1'b1}}) &
                            (period_compare_value != 3'h0);
   wire             a_hit = (count == compare_a_value - {{(CNT_W-1){1'b0}}, 1'b1}) &
                            (compare_a_value != {CNT_W{1'b0}});
   wire             ovf   = (count == `CTM_CNT_MAX);

   reg              clr_cnt;
   reg              set_a;
   reg              set_p;
   always @* begin
      clr_cnt = 1'b0;
      set_a = 1'b0;
      set_p = 1'b0;
      if (is_pwm) begin
         set_a = a_hit;
         set_p = p_hit | (period_compare_value == 3'h0 & ovf);
         if (swap)
            clr_cnt = a_hit | ovf;
         else
            clr_cnt = set_p;
      end else if (is_cmp) begin
         if (clear_select) begin
            set_a = a_hit;
            clr_cnt = a_hit | ovf;
         end else begin
            set_a = a_hit;
            set_p = p_hit | (period_compare_value == 3'h0 & ovf);
            clr_cnt = set_p | ovf;
         end
      end else begin
         clr_cnt = ovf;
      end
   end

   // Duty compare: count below the duty threshold is the active phase
   wire [CNT_W:0]   duty_thr = swap ? ctm_scale(period_compare_value)
                                    : {1'b0, compare_a_value};
   wire [CNT_W:0]   per_thr  = swap ? ((compare_a_value == {CNT_W{1'b0}}) ?
                                       ctm_scale(3'h0) : {1'b0, compare_a_value})
                                    : ctm_scale(period_compare_value);
   wire             duty_act = (duty_thr >= per_thr) | ({1'b0, count} < duty_thr);

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count <= {CNT_W{1'b0}};
         on_dly <= 1'b0;
         pwm_wave <= 1'b0;
      end else begin
         on_dly <= counter_on;
         if (on_rise)
            count <= {CNT_W{1'b0}};
         else if (run)
            count <= clr_cnt ? {CNT_W{1'b0}} : count + {{(CNT_W-1){1'b0}}, 1'b1};
         pwm_wave <= duty_act;
      end
   end

   wire [7:0] wr_byte = i_writedata[7:0];
   // Writes land only at the edge where the master sees waitrequest low
   wire       wr_en    = i_write & ~o_waitrequest;
   wire       bus_acc  = (i_read | i_write) & o_waitrequest;

   // One wait state gives a registered read path and a fixed two-cycle access
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_waitrequest <= 1'b1;
         o_readdata <= 32'h00000000;
         ctrl0 <= `CTM_RST_BYTE;
         ctrl1 <= `CTM_RST_BYTE;
         compare_a_value <= {CNT_W{1'b0}};
         match_a_flag <= 1'b0;
         match_p_flag <= 1'b0;
      end else begin
         o_waitrequest <= ~bus_acc;
         if (wr_en) begin
            if (i_address == `CTM_ADDR_CTRL0)
               ctrl0 <= wr_byte;
            else if (i_address == `CTM_ADDR_CTRL1)
               ctrl1 <= wr_byte;
            else if (i_address == `CTM_ADDR_CMPA_LO)
               compare_a_value[7:0] <= wr_byte;
            else if (i_address == `CTM_ADDR_CMPA_HI)
               compare_a_value[CNT_W-1:8] <= wr_byte[CNT_W-9:0];
         end
         // Set wins over a same-cycle write-one clear
         if (run & set_a)
            match_a_flag <= 1'b1;
         else if (wr_en & i_address == `CTM_ADDR_FLAGS & wr_byte[`CTM_BIT_FLAG_A])
            match_a_flag <= 1'b0;
         if (run & set_p)
            match_p_flag <= 1'b1;
         else if (wr_en & i_address == `CTM_ADDR_FLAGS & wr_byte[`CTM_BIT_FLAG_P])
            match_p_flag <= 1'b0;
         o_readdata <= 32'h00000000;
         if (bus_acc & i_read) begin
            if (i_address == `CTM_ADDR_CTRL0)
               o_readdata[7:0] <= ctrl0;
            else if (i_address == `CTM_ADDR_CTRL1)
               o_readdata[7:0] <= ctrl1;
            else if (i_address == `CTM_ADDR_CNT_LO)
               o_readdata[7:0] <= count[7:0];
            else if (i_address == `CTM_ADDR_CNT_HI)
               o_readdata[CNT_W-9:0] <= count[CNT_W-1:8];
            else if (i_address == `CTM_ADDR_CMPA_LO)
               o_readdata[7:0] <= compare_a_value[7:0];
            else if (i_address == `CTM_ADDR_CMPA_HI)
               o_readdata[CNT_W-9:0] <= compare_a_value[CNT_W-1:8];
            else if (i_address == `CTM_ADDR_FLAGS)
               o_readdata[1:0] <= {match_p_flag, match_a_flag};
         end
      end
   end

   reg cmp_level;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmp_level <= 1'b0;
         o_pin <= 1'b0;
         o_pin_oe <= 1'b0;
      end else begin
         if (on_rise)
            cmp_level <= init_lvl;
         else if (run & set_a & (mode == `CTM_MODE_CMP)) begin
            case (act)
               `CTM_ACT_LOW:    cmp_level <= 1'b0;
               `CTM_ACT_HIGH:   cmp_level <= 1'b1;
               `CTM_ACT_TOGGLE: cmp_level <= ~cmp_level;
               default:         cmp_level <= cmp_level;
            endcase
         end
         o_pin_oe <= ~(mode == `CTM_MODE_TMR) & (mode != 2'h1);
         if (is_pwm) begin
            case (act)
               `CTM_PWM_INACTIVE: o_pin <= ~init_lvl ^ invert;
               `CTM_PWM_ACTIVE:   o_pin <= init_lvl ^ invert;
               `CTM_PWM_WAVE:     o_pin <= (pwm_wave ? init_lvl : ~init_lvl) ^ invert;
               default:           o_pin <= 1'b0;
            endcase
         end else if (mode == `CTM_MODE_CMP)
            o_pin <= (on_rise ? init_lvl : cmp_level) ^ invert;
         else
            o_pin <= 1'b0;
      end
   end

endmodule // ctm_timer

/* test/ctm_timer_chk.sv */
`timescale 1ns/1ps
module ctm_timer_chk (
   input wire        i_clk,
   input wire        i_rst_n,
   input wire        i_tick,
   input wire [3:0]  i_address,
   input wire        i_read,
   input wire        i_write,
   input wire [31:0] i_writedata,
   input wire [31:0] o_readdata,
   input wire        o_waitrequest,
   input wire        o_pin,
   input wire        o_pin_oe
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire rd_ok = i_read && !o_waitrequest;
   chk_wait_answer: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
      else $error("access not answered");
   chk_wait_single: assert property (!o_waitrequest |=> o_waitrequest) else $error("long answer");
   chk_rdata_idle: assert property (o_waitrequest |-> o_readdata == 32'h0) else $error("stray data");
   chk_cmpa_high: assert property (rd_ok && i_address == 4'h5 |-> o_readdata[31:2] == 30'h0)
      else $error("compare high bits");
   chk_cnt_high: assert property (rd_ok && i_address == 4'h3 |-> o_readdata[31:2] == 30'h0)
      else $error("counter high bits");
   chk_flag_bits: assert property (rd_ok && i_address == 4'h6 |-> o_readdata[31:2] == 30'h0)
      else $error("flag bits");
   chk_unmapped_zero: assert property (rd_ok && i_address > 4'h6 |-> o_readdata == 32'h0)
      else $error("unmapped data");
   // Pin may only move after a timer tick or a register write
   chk_pin_cause: assert property (!$past(i_tick) && !$past(i_tick, 2) && !$past(i_write) &&
      !$past(i_write, 2) |-> $stable(o_pin)) else $error("pin moved without cause");
   cover property (rd_ok && i_address == 4'h6 && o_readdata[1:0] == 2'h3);
   cover property ($rose(o_pin));
   cover property ($fell(o_pin));
endmodule // ctm_timer_chk
bind ctm_timer ctm_timer_chk u_ctm_timer_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tick(i_tick),
   .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
   .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_pin(o_pin), .o_pin_oe(o_pin_oe));

/* test/ctm_timer_tb.sv */
`timescale 1ns/1ps
module ctm_timer_tb;
   reg         i_clk = 1'b0;
   reg         i_rst_n = 1'b0;
   reg         i_tick = 1'b0;
   reg  [3:0]  i_address = 4'h0;
   reg         i_read = 1'b0;
   reg         i_write = 1'b0;
   reg  [31:0] i_writedata = 32'h0;
   wire [31:0] o_readdata;
   wire        o_waitrequest;
   wire        o_pin;
   wire        o_pin_oe;
   reg  [31:0] rdv;
   reg  [31:0] rdw;
   integer     num_errors = 0;
   integer     checked = 0;
   integer     cyc = 0;
   integer     k;
   always #5 i_clk = ~i_clk;
   ctm_timer u_ctm_timer (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tick(i_tick),
      .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_pin(o_pin), .o_pin_oe(o_pin_oe));
   task give_verdict;
      begin
         $display("errors %0d checked %0d", num_errors, checked);
         if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] s, input [31:0] e);
      begin
         checked = checked + 1;
         if (s !== e) begin
            num_errors = num_errors + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
         end
      end
   endtask
   // Extra edge after release keeps back-to-back calls from driving twice in one step
   task acc(input w, input [3:0] a, input [7:0] d);
      begin
         i_address <= a;
         i_writedata <= {24'h0, d};
         i_write <= w;
         i_read <= !w;
         // Registered answer is settled by the falling edge and stands to the next rise
         @(negedge i_clk);
         while (o_waitrequest) @(negedge i_clk);
         rdv = o_readdata;
         @(posedge i_clk);
         i_read <= 1'b0;
         i_write <= 1'b0;
         @(posedge i_clk);
      end
   endtask
   task rc(input [3:0] a, input [31:0] e);
      begin
         acc(1'b0, a, 8'h00);
         chk(rdv, e);
      end
   endtask
   // Mode bits change only with the counter off; period code 1 gives 128 ticks
   task start(input [7:0] c1);
      begin
         acc(1'b1, 4'h0, 8'h00);
         acc(1'b1, 4'h1, c1);
         acc(1'b1, 4'h6, 8'h03);
         acc(1'b1, 4'h0, 8'h09);
         @(posedge i_clk);
      end
   endtask
   task pwm(input [7:0] c1, input [7:0] a, input p, input [1:0] f);
      begin
         acc(1'b1, 4'h4, a);
         start(c1);
         repeat (300) @(posedge i_clk);
         chk({31'h0, o_pin}, {31'h0, p});
         chk({31'h0, o_pin_oe}, 32'h1);
         rc(4'h6, {30'h0, f});
      end
   endtask
   always @(posedge i_clk) begin
      cyc = cyc + 1;
      if (cyc > 6000) begin
         num_errors = num_errors + 1;
         give_verdict;
      end
   end
   initial begin
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (k = 0; k < 8; k = k + 1) rc(k[3:0], 32'h0);
      acc(1'b1, 4'h7, 8'h5A);
      rc(4'h7, 32'h0);
      acc(1'b1, 4'h4, 8'hAB);
      acc(1'b1, 4'h5, 8'hFF);
      rc(4'h4, 32'hAB);
      rc(4'h5, 32'h3);
      $display("end registers");
      acc(1'b1, 4'h5, 8'h00);
      acc(1'b1, 4'h4, 8'h0A);
      i_tick <= 1'b1;
      start(8'h19);
      chk({31'h0, o_pin}, 32'h1);
      repeat (300) @(posedge i_clk);
      chk({31'h0, o_pin}, 32'h0);
      rc(4'h6, 32'h1);
      rc(4'h3, 32'h0);
      acc(1'b1, 4'h0, 8'h00);
      acc(1'b0, 4'h2, 8'h00);
      rdw = rdv;
      rc(4'h2, rdw);
      acc(1'b1, 4'h6, 8'h03);
      rc(4'h6, 32'h0);
      $display("end compare clear on A");
      start(8'h30);
      chk({31'h0, o_pin_oe}, 32'h1);
      repeat (300) @(posedge i_clk);
      rc(4'h6, 32'h3);
      rc(4'h3, 32'h0);
      $display("end compare clear on P");
      start(8'hC0);
      chk({31'h0, o_pin_oe}, 32'h0);
      repeat (300) @(posedge i_clk);
      rc(4'h6, 32'h3);
      $display("end timer mode");
      pwm(8'hA8, 8'hC8, 1'b1, 2'h2);
      pwm(8'hA9, 8'hC8, 1'b1, 2'h2);
      pwm(8'hAC, 8'hC8, 1'b0, 2'h2);
      pwm(8'h88, 8'hC8, 1'b0, 2'h2);
      pwm(8'h98, 8'hC8, 1'b1, 2'h2);
      pwm(8'hAA, 8'h0A, 1'b1, 2'h1);
      $display("end pwm");
      acc(1'b1, 4'h4, 8'h00);
      start(8'h19);
      repeat (1100) @(posedge i_clk);
      rc(4'h6, 32'h0);
      chk({31'h0, o_pin}, 32'h1);
      $display("end overflow with compare A zero");
      give_verdict;
   end
endmodule // ctm_timer_tb
